// file: core/dcr_bank.sv
`timescale 1ns/1ps
`include "dcr_cfg.svh"
module dcr_bank #(
	parameter logic [31:0] OVERLOAD_CYCLES = 32'(`DCR_OVERLOAD_CYCLES)
) (
	input wire logic clk, // 25 MHz clock
	input wire logic reset_n, // async reset
	input wire dcr_pkg::dcr_req_s req, // register request
	output dcr_pkg::dcr_rsp_s rsp_q, // register answer
	input wire logic freq_source_comm, // frequency source is link
	input wire logic run_source_comm, // run source is link
	input wire logic [3:0] loop_reference_source_setting, // loop ref source
	input wire logic [3:0] loop_feedback_source_setting, // loop fb source
	input wire logic overcurrent_flag, // current above rated
	input wire logic overload_flag, // current at 150 percent
	input wire logic [9:0] dc_bus_volts, // dc bus in volts
	input wire logic decelerating, // drive decelerating
	input wire logic trip_reset, // clear trips
	output dcr_pkg::dcr_cmd_s cmd_q, // command values
	output logic run_q, // run command
	output logic forward_q, // forward rotation
	output logic coast_stop_q, // coast start pulse
	output logic drive_on_q, // output stage enable
	output logic tripped_q, // trip active
	output dcr_pkg::dcr_trip_s trip_cause_q, // latched causes
	output logic init_req_q, // parameter init pulse
	output dcr_pkg::dcr_init_e init_group_q, // group to init
	output logic history_clear_q // erase fault history pulse
);
	// =========================================
	// address decode
	wire hit_freq = req.addr == `DCR_OFS_FREQ;
	wire hit_speed = req.addr == `DCR_OFS_SPEED;
	wire hit_oper = req.addr == `DCR_OFS_OPER;
	wire hit_accel = req.addr == `DCR_OFS_ACCEL;
	wire hit_decel = req.addr == `DCR_OFS_DECEL;
	wire hit_lref = req.addr == `DCR_OFS_LREF;
	wire hit_lfb = req.addr == `DCR_OFS_LFB;
	wire hit_init = req.addr == `DCR_OFS_INIT;
	wire hit_hist = req.addr == `DCR_OFS_HIST;
	wire hit_any = hit_freq | hit_speed | hit_oper | hit_accel | hit_decel | hit_lref
		| hit_lfb | hit_init | hit_hist;

	// =========================================
	// write gating by command source, trip state and init value range
	wire lref_ok = loop_reference_source_setting == `DCR_LREF_SRC_COMM;
	wire lfb_ok = loop_feedback_source_setting == `DCR_LFB_SRC_COMM;
	wire init_ok = ~tripped_q & (req.wdata <= `DCR_INIT_MAX);
	wire wr_freq = req.wr & hit_freq & freq_source_comm;
	wire wr_speed = req.wr & hit_speed & freq_source_comm;
	wire wr_oper = req.wr & hit_oper & run_source_comm;
	wire wr_accel = req.wr & hit_accel;
	wire wr_decel = req.wr & hit_decel;
	wire wr_lref = req.wr & hit_lref & lref_ok;
	wire wr_lfb = req.wr & hit_lfb & lfb_ok;
	wire wr_init = req.wr & hit_init & init_ok;
	wire wr_hist = req.wr & hit_hist;
	wire refused = req.wr & (((hit_freq | hit_speed) & ~freq_source_comm)
		| (hit_oper & ~run_source_comm) | (hit_lref & ~lref_ok)
		| (hit_lfb & ~lfb_ok) | (hit_init & ~init_ok));

	// =========================================
	// storage
	logic [15:0] oper_q;
	logic [15:0] init_q;
	logic [15:0] hist_q;
	logic coasting_q;
	logic coast_rise;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cmd_q.frequency <= `DCR_REG_RESET;
		else if (wr_freq)
			cmd_q.frequency <= req.wdata;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cmd_q.speed <= `DCR_REG_RESET;
		else if (wr_speed)
			cmd_q.speed <= req.wdata;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cmd_q.accel <= `DCR_REG_RESET;
		else if (wr_accel)
			cmd_q.accel <= req.wdata;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cmd_q.decel <= `DCR_REG_RESET;
		else if (wr_decel)
			cmd_q.decel <= req.wdata;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cmd_q.loop_ref <= `DCR_REG_RESET;
		else if (wr_lref)
			cmd_q.loop_ref <= req.wdata;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cmd_q.loop_fb <= `DCR_REG_RESET;
		else if (wr_lfb)
			cmd_q.loop_fb <= req.wdata;
	end

	// reserved bits never stored so they read as zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			oper_q <= `DCR_REG_RESET;
		else if (wr_oper)
			oper_q <= req.wdata & `DCR_OPER_MASK;
	end

	// =========================================
	// run, direction and coast stop
	assign run_q = oper_q[`DCR_OPER_RUN_BIT];
	assign forward_q = oper_q[`DCR_OPER_FWD_BIT];

	dcr_rise u_coast_edge (
		.clk(clk),
		.reset_n(reset_n),
		.level(oper_q[`DCR_OPER_COAST_BIT]),
		.pulse_q(coast_rise)
	);
	assign coast_stop_q = coast_rise;

	// coasting holds until run is withdrawn; a new edge wins over the release
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			coasting_q <= 1'b0;
		else if (coast_rise)
			coasting_q <= 1'b1;
		else if (!oper_q[`DCR_OPER_RUN_BIT])
			coasting_q <= 1'b0;
	end

	// =========================================
	// protection
	logic trip_now;

	dcr_trip #(
		.OVERLOAD_CYCLES(OVERLOAD_CYCLES)
	) u_trip (
		.clk(clk),
		.reset_n(reset_n),
		.overcurrent_flag(overcurrent_flag),
		.overload_flag(overload_flag),
		.dc_bus_volts(dc_bus_volts),
		.decelerating(decelerating),
		.trip_reset(trip_reset),
		.cause_q(trip_cause_q),
		.tripped_q(trip_now)
	);
	assign tripped_q = trip_now;

	// output cut one cycle after a trip or coast pulse appears
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			drive_on_q <= 1'b0;
		else
			drive_on_q <= oper_q[`DCR_OPER_RUN_BIT] & ~trip_now & ~coasting_q
				& ~coast_rise;
	end

	// =========================================
	// memory control
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			init_q <= `DCR_REG_RESET;
			init_req_q <= 1'b0;
			init_group_q <= dcr_pkg::DCR_INIT_NONE;
		end else begin
			init_req_q <= wr_init & (req.wdata != `DCR_REG_RESET);
			if (wr_init) begin
				init_q <= req.wdata;
				init_group_q <= dcr_pkg::dcr_init_e'(req.wdata[2:0]);
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hist_q <= `DCR_REG_RESET;
			history_clear_q <= 1'b0;
		end else begin
			history_clear_q <= wr_hist & (req.wdata == `DCR_HIST_ERASE);
			if (wr_hist)
				hist_q <= req.wdata;
		end
	end

	// =========================================
	// read mux and answer
	wire [15:0] rd_mux = hit_freq ? cmd_q.frequency :
		hit_speed ? cmd_q.speed :
		hit_oper ? oper_q :
		hit_accel ? cmd_q.accel :
		hit_decel ? cmd_q.decel :
		hit_lref ? cmd_q.loop_ref :
		hit_lfb ? cmd_q.loop_fb :
		hit_init ? init_q :
		hit_hist ? hist_q : 16'h0000;
	wire access = req.wr | req.rd;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rsp_q <= '0;
		else begin
			rsp_q.valid <= access;
			rsp_q.refused <= refused;
			rsp_q.unmapped <= access & ~hit_any;
			rsp_q.rdata <= req.rd ? rd_mux : 16'h0000;
		end
	end
endmodule

// file: core/dcr_cfg.svh
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH

// =========================================
// register offsets
`define DCR_OFS_FREQ 16'h0380
`define DCR_OFS_SPEED 16'h0381
`define DCR_OFS_OPER 16'h0382
`define DCR_OFS_ACCEL 16'h0383
`define DCR_OFS_DECEL 16'h0384
`define DCR_OFS_LREF 16'h0388
`define DCR_OFS_LFB 16'h0389
`define DCR_OFS_INIT 16'h03e2
`define DCR_OFS_HIST 16'h03e5

// =========================================
// fields and reset values
`define DCR_OPER_RUN_BIT 0
`define DCR_OPER_FWD_BIT 1
`define DCR_OPER_COAST_BIT 3
`define DCR_OPER_MASK 16'h000b
`define DCR_REG_RESET 16'h0000
`define DCR_LREF_SRC_COMM 4'h4
`define DCR_LFB_SRC_COMM 4'h2
`define DCR_INIT_MAX 16'h0005
`define DCR_HIST_ERASE 16'h0001

// =========================================
// trip thresholds and timing
`define DCR_OV_VOLTS 10'h190
`define DCR_UV_VOLTS 10'h0b4
`define DCR_CLK_HZ 64'd25000000
`define DCR_OVERLOAD_TIME_S 64'd60
`define DCR_OVERLOAD_CYCLES (`DCR_OVERLOAD_TIME_S * `DCR_CLK_HZ)
`endif

// file: core/dcr_pkg.sv
package dcr_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dcr_req_s;

	typedef struct packed {
		logic valid;
		logic refused;
		logic unmapped;
		logic [15:0] rdata;
	} dcr_rsp_s;

	typedef struct packed {
		logic [15:0] frequency;
		logic [15:0] speed;
		logic [15:0] accel;
		logic [15:0] decel;
		logic [15:0] loop_ref;
		logic [15:0] loop_fb;
	} dcr_cmd_s;

	typedef struct packed {
		logic overcurrent;
		logic overload;
		logic overvoltage;
		logic undervoltage;
	} dcr_trip_s;

	typedef enum logic [2:0] {
		DCR_INIT_NONE,
		DCR_INIT_ALL,
		DCR_INIT_DRIVE,
		DCR_INIT_FUNC1,
		DCR_INIT_FUNC2,
		DCR_INIT_IO
	} dcr_init_e;
endpackage

// file: core/dcr_rise.sv
`timescale 1ns/1ps
module dcr_rise (
	input wire logic clk, // clock
	input wire logic reset_n, // async reset
	input wire logic level, // watched level
	output logic pulse_q // one-cycle rise pulse
);
	logic prev_q;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= 1'b0;
			pulse_q <= 1'b0;
		end else begin
			prev_q <= level;
			pulse_q <= level & ~prev_q;
		end
	end
endmodule

// file: core/dcr_trip.sv
`timescale 1ns/1ps
`include "dcr_cfg.svh"
module dcr_trip #(
	parameter logic [31:0] OVERLOAD_CYCLES = 32'(`DCR_OVERLOAD_CYCLES)
) (
	input wire logic clk, // clock
	input wire logic reset_n, // async reset
	input wire logic overcurrent_flag, // current above rated
	input wire logic overload_flag, // current at 150 percent
	input wire logic [9:0] dc_bus_volts, // dc bus in volts
	input wire logic decelerating, // drive decelerating
	input wire logic trip_reset, // clear latched causes
	output dcr_pkg::dcr_trip_s cause_q, // latched causes
	output logic tripped_q // any trip active
);
	logic [31:0] ol_cnt_q;
	wire ol_expired = ol_cnt_q == OVERLOAD_CYCLES;
	dcr_pkg::dcr_trip_s set_now;
	dcr_pkg::dcr_trip_s cause_d;

	assign set_now.overcurrent = overcurrent_flag;
	assign set_now.overload = overload_flag & ol_expired;
	assign set_now.overvoltage = decelerating & (dc_bus_volts > `DCR_OV_VOLTS);
	assign set_now.undervoltage = dc_bus_volts < `DCR_UV_VOLTS;
	// set wins over a simultaneous clear
	assign cause_d = (trip_reset ? '0 : cause_q) | set_now;

	// =========================================
	// overload duration
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			ol_cnt_q <= 32'h0;
		else if (!overload_flag)
			ol_cnt_q <= 32'h0;
		else if (!ol_expired)
			ol_cnt_q <= ol_cnt_q + 32'h1;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cause_q <= '0;
			tripped_q <= 1'b0;
		end else begin
			cause_q <= cause_d;
			tripped_q <= |cause_d;
		end
	end
endmodule

// file: verification/dcr_bank_tb.sv
`timescale 1ns/1ps
// ====
// bank testbench
module dcr_bank_tb;
	typedef struct packed {
		logic [15:0] a;
		logic [15:0] d;
		logic ok;
		logic rf;
		logic [15:0] rd;
	} dcr_row_s;
	typedef struct packed {
		logic oc;
		logic dec;
		logic [9:0] v;
		logic [3:0] e;
	} dcr_trow_s;
	logic clk, reset_n, freq_source_comm, run_source_comm, overcurrent_flag, overload_flag;
	logic decelerating, trip_reset, run_q, forward_q, coast_stop_q, drive_on_q, tripped_q;
	logic init_req_q, history_clear_q;
	logic [3:0] loop_reference_source_setting, loop_feedback_source_setting;
	logic [9:0] dc_bus_volts;
	dcr_pkg::dcr_req_s req;
	dcr_pkg::dcr_rsp_s rsp_q, r;
	dcr_pkg::dcr_cmd_s cmd_q;
	dcr_pkg::dcr_trip_s trip_cause_q;
	dcr_pkg::dcr_init_e init_group_q;
	int miscompares = 0;
	int num_checks = 0;
	dcr_row_s rows [15] = '{
		'{16'h0380, 16'h1234, 1'h1, 1'h0, 16'h1234}, '{16'h0380, 16'h5555, 1'h0, 1'h1, 16'h1234},
		'{16'h0381, 16'h0bb8, 1'h1, 1'h0, 16'h0bb8}, '{16'h0381, 16'h0001, 1'h0, 1'h1, 16'h0bb8},
		'{16'h0382, 16'h0002, 1'h0, 1'h1, 16'h0000}, '{16'h0382, 16'h00f6, 1'h1, 1'h0, 16'h0002},
		'{16'h0383, 16'h0032, 1'h0, 1'h0, 16'h0032}, '{16'h0384, 16'h0064, 1'h0, 1'h0, 16'h0064},
		'{16'h0388, 16'h03e8, 1'h1, 1'h0, 16'h03e8}, '{16'h0388, 16'h0001, 1'h0, 1'h1, 16'h03e8},
		'{16'h0389, 16'h01f4, 1'h1, 1'h0, 16'h01f4}, '{16'h0389, 16'h0002, 1'h0, 1'h1, 16'h01f4},
		'{16'h03e2, 16'h0006, 1'h1, 1'h1, 16'h0000}, '{16'h03e5, 16'h0000, 1'h1, 1'h0, 16'h0000},
		'{16'h0300, 16'hffff, 1'h1, 1'h0, 16'h0000}};
	dcr_trow_s trips [5] = '{'{1'h0, 1'h1, 10'h190, 4'h0}, '{1'h0, 1'h1, 10'h191, 4'h2},
		'{1'h0, 1'h0, 10'h0b4, 4'h0}, '{1'h0, 1'h0, 10'h0b3, 4'h1}, '{1'h1, 1'h0, 10'h12c, 4'h8}};
	dcr_bank #(.OVERLOAD_CYCLES(32'h14)) uut (.*);
	dcr_master m (.clk(clk), .rsp(rsp_q), .req(req));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// drop every trip cause, then pulse the clear
	task automatic clr;
		overcurrent_flag = 1'h0;
		overload_flag = 1'h0;
		decelerating = 1'h0;
		dc_bus_volts = 10'h12c;
		trip_reset = 1'h1;
		@(negedge clk) trip_reset = 1'h0;
		@(negedge clk) chk(tripped_q, 1'h0);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	initial begin
		#100000;
		miscompares++;
		wrap_up;
	end
	initial begin
		{reset_n, freq_source_comm, run_source_comm, overcurrent_flag, overload_flag} = '0;
		{decelerating, trip_reset, loop_reference_source_setting} = '0;
		loop_feedback_source_setting = 4'h0;
		dc_bus_volts = 10'h12c;
		repeat (2) @(negedge clk);
		reset_n = 1'h1;
		chk(run_q, 1'h0);
		chk(cmd_q.speed, 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 15; i++) begin
			freq_source_comm = rows[i].ok;
			run_source_comm = rows[i].ok;
			loop_reference_source_setting = rows[i].ok ? 4'h4 : 4'h5;
			loop_feedback_source_setting = rows[i].ok ? 4'h2 : 4'h3;
			m.xfer(1'h1, rows[i].a, rows[i].d, r);
			chk(r.refused, rows[i].rf);
			chk({r.valid, r.unmapped}, {1'h1, rows[i].a == 16'h0300});
			m.xfer(1'h0, rows[i].a, 16'h0000, r);
			chk(r.rdata, rows[i].rd);
		end
		chk(cmd_q.loop_fb, 16'h01f4);
		$display("test table done");
		m.xfer(1'h1, 16'h0382, 16'h000b, r);
		chk({run_q, forward_q}, 2'h3);
		@(negedge clk) chk(coast_stop_q, 1'h1);
		@(negedge clk) chk(coast_stop_q, 1'h0);
		chk(drive_on_q, 1'h0);
		m.xfer(1'h1, 16'h0382, 16'h000b, r);
		@(negedge clk) chk(coast_stop_q, 1'h0);
		m.xfer(1'h1, 16'h0382, 16'h0000, r);
		m.xfer(1'h1, 16'h0382, 16'h0001, r);
		@(negedge clk) chk(drive_on_q, 1'h1);
		$display("test coast done");
		for (int g = 0; g < 6; g++) begin
			m.xfer(1'h1, 16'h03e2, 16'(g), r);
			chk(init_req_q, g != 0);
			if (g != 0) chk(init_group_q, 16'(g));
		end
		m.xfer(1'h1, 16'h03e5, 16'h0001, r);
		chk(history_clear_q, 1'h1);
		m.xfer(1'h1, 16'h03e5, 16'h0000, r);
		chk(history_clear_q, 1'h0);
		$display("test init done");
		for (int i = 0; i < 5; i++) begin
			overcurrent_flag = trips[i].oc;
			decelerating = trips[i].dec;
			dc_bus_volts = trips[i].v;
			@(negedge clk) chk(trip_cause_q, trips[i].e);
			@(negedge clk) chk(drive_on_q, trips[i].e == 4'h0);
			clr;
		end
		overload_flag = 1'h1;
		repeat (20) @(negedge clk);
		chk(trip_cause_q.overload, 1'h0);
		@(negedge clk) chk(trip_cause_q.overload, 1'h1);
		clr;
		overcurrent_flag = 1'h1;
		m.xfer(1'h1, 16'h03e2, 16'h0001, r);
		chk(r.refused, 1'h1);
		chk(init_req_q, 1'h0);
		clr;
		$display("test trips done");
		reset_n = 1'h0;
		@(negedge clk) chk(cmd_q.frequency, 16'h0000);
		chk(run_q, 1'h0);
		reset_n = 1'h1;
		$display("test second reset done");
		wrap_up;
	end
endmodule

// file: verification/dcr_checker.sv
`timescale 1ns/1ps
// ====
// bank port checker
module dcr_checker #(
	parameter logic [31:0] OVERLOAD_CYCLES = 32'h59682f00
) (
	input wire logic clk, // clock
	input wire logic reset_n, // reset
	input wire dcr_pkg::dcr_req_s req, // request
	input wire dcr_pkg::dcr_rsp_s rsp_q, // answer
	input wire logic freq_source_comm, // freq src
	input wire logic run_source_comm, // run src
	input wire logic overcurrent_flag, // oc
	input wire logic overload_flag, // ol
	input wire logic [9:0] dc_bus_volts, // bus
	input wire logic decelerating, // decel
	input wire dcr_pkg::dcr_cmd_s cmd_q, // commands
	input wire logic run_q, // run
	input wire logic forward_q, // dir
	input wire logic coast_stop_q, // coast
	input wire logic drive_on_q, // enable
	input wire logic tripped_q, // trip
	input wire dcr_pkg::dcr_trip_s trip_cause_q, // causes
	input wire logic init_req_q, // init
	input wire dcr_pkg::dcr_init_e init_group_q, // group
	input wire logic history_clear_q // clear
);
	wire logic w380 = req.wr && req.addr == 16'h0380;
	wire logic w382 = req.wr && req.addr == 16'h0382 && run_source_comm;
	wire logic w3e2 = req.wr && req.addr == 16'h03e2 && !tripped_q;
	wire logic w3e5 = req.wr && req.addr == 16'h03e5;
	wire logic coast_set = w382 && req.wdata[3];
	logic [31:0] ol_n_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// consecutive cycles with the overload flag high
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) ol_n_q <= '0;
		else if (!overload_flag) ol_n_q <= '0;
		else if (ol_n_q != OVERLOAD_CYCLES) ol_n_q <= ol_n_q + 32'h1;
	end
	a_freq_gate: assert property (w380 && !freq_source_comm |=> rsp_q.refused
		&& $stable(cmd_q.frequency)) else $error("gated frequency write taken");
	a_oper_bits: assert property (w382 |=> run_q == $past(req.wdata[0])
		&& forward_q == $past(req.wdata[1])) else $error("run or direction wrong");
	a_coast_edge: assert property (coast_stop_q |-> $past(coast_set, 2)
		##1 !coast_stop_q) else $error("coast pulse without bit rise");
	a_init_pulse: assert property (w3e2 && req.wdata inside {[16'h0001:16'h0005]}
		|=> init_req_q && init_group_q == $past(req.wdata[2:0])) else $error("init missed");
	a_hist_clear: assert property (w3e5 |=>
		history_clear_q == ($past(req.wdata) == 16'h0001)) else $error("history clear wrong");
	a_overload_time: assert property (ol_n_q == OVERLOAD_CYCLES && overload_flag
		|=> trip_cause_q.overload) else $error("overload trip late");
	a_uv_trip: assert property (dc_bus_volts < 10'h0b4
		|=> trip_cause_q.undervoltage && tripped_q) else $error("undervoltage missed");
	a_oc_trip: assert property (overcurrent_flag |=> trip_cause_q.overcurrent
		&& tripped_q ##1 !drive_on_q) else $error("overcurrent trip missed");
	a_ov_trip: assert property (decelerating && dc_bus_volts > 10'h190
		|=> trip_cause_q.overvoltage && tripped_q) else $error("overvoltage missed");
	a_init_tripped: assert property (req.wr && req.addr == 16'h03e2 && tripped_q
		|=> rsp_q.refused && !init_req_q) else $error("init taken during trip");
endmodule
bind dcr_bank dcr_checker #(.OVERLOAD_CYCLES(OVERLOAD_CYCLES)) chk_i (.*);

// file: verification/dcr_master.sv
`timescale 1ns/1ps
// ====
// link master model
module dcr_master (
	input wire logic clk, // clock
	input wire dcr_pkg::dcr_rsp_s rsp, // bank answer
	output dcr_pkg::dcr_req_s req // bank request
);
	initial req = '0;
	// one word, taken at one edge; released lines show the inverse
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
		output dcr_pkg::dcr_rsp_s r);
		@(negedge clk);
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk);
		r = rsp;
		req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
	endtask
endmodule
